// ### compare_unit_map.vh
// Operation
// - compare full count with each compare value
// - match flag sets on the following tick
// - enabled flag requests irq; ack or one clears
// - compare a can set counter top
// - pwm modes buffer compare; others do not
// - buffer moves to compare at top/bottom
// - cpu writes buffer or compare per mode
// - only cpu changes compare; high read direct
// - high byte latched; low write moves sixteen
// - force updates output bit in non-pwm only, no flag, no clear
// - count write blocks matches next tick
// - count written at top runs to max
// - output bit kept across mode changes
// - output mode unbuffered, acts next match
// - reset clears output bits
// - nonzero output mode overrides port value
// - output mode zero leaves bit alone
// - output mode never touches counting sequence
// - output mode one toggles in non-pwm
// - normal mode counts up, wraps to zero
// - normal overflow sets as count hits zero
// - clear-on-match clears at compare a or capture
// - clear-on-match overflow sets on wrap only
`ifndef COMPARE_UNIT_MAP_VH
`define COMPARE_UNIT_MAP_VH

`define ADDR_W       8
`define REG_CTRL_A   8'h00
`define REG_FORCE    8'h04
`define REG_COUNT    8'h08
`define REG_CMPA_LO  8'h0C
`define REG_CMPA_HI  8'h10
`define REG_CMPB_LO  8'h14
`define REG_CMPB_HI  8'h18
`define REG_CAPTURE  8'h1C
`define REG_FLAGS    8'h20
`define REG_MASK     8'h24

`define COM_W        2
`define WGM_LSB      4
`define WGM_MSB      7
`define NFLAGS       3
`define FLAG_OVF     0

`define WGM_NORMAL   4'h0
`define WGM_PC8      4'h1
`define WGM_PC9      4'h2
`define WGM_PC10     4'h3
`define WGM_CTC_A    4'h4
`define WGM_FP8      4'h5
`define WGM_FP9      4'h6
`define WGM_FP10     4'h7
`define WGM_PFC_CAP  4'h8
`define WGM_PFC_A    4'h9
`define WGM_PC_CAP   4'hA
`define WGM_PC_A     4'hB
`define WGM_CTC_CAP  4'hC
`define WGM_FP_CAP   4'hE
`define WGM_FP_A     4'hF

`define TOP_8        16'h00FF
`define TOP_9        16'h01FF
`define TOP_10       16'h03FF
`define CNT_MAX      16'hFFFF
`define CNT_BOTTOM   16'h0000

`define COM_OFF      2'h0
`define COM_TOGGLE   2'h1
`define COM_CLEAR    2'h2
`define COM_SET      2'h3

`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2

`define RST_BYTE     8'h00
`define RST_WORD     16'h0000
`define RST_FLAGS    3'h0
`define DATA_ZERO    32'h0000_0000

`endif

// ### output_compare_waveform_unit.v
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "compare_unit_map.vh"

module output_compare_waveform_unit (
    input  wire                clock,
    input  wire                nrst,
    input  wire                timerTick,
    input  wire [1:0]          portOut,
    input  wire [1:0]          portDir,
    input  wire [2:0]          irqAck,
    input  wire [`ADDR_W-1:0]  awaddr,
    input  wire                awvalid,
    output reg                 awready,
    input  wire [31:0]         wdata,
    input  wire [3:0]          wstrb,
    input  wire                wvalid,
    output reg                 wready,
    output reg  [1:0]          bresp,
    output reg                 bvalid,
    input  wire                bready,
    input  wire [`ADDR_W-1:0]  araddr,
    input  wire                arvalid,
    output reg                 arready,
    output reg  [31:0]         rdata,
    output reg  [1:0]          rresp,
    output reg                 rvalid,
    input  wire                rready,
    output reg  [1:0]          pinOut,
    output reg  [1:0]          pinOe,
    output reg  [2:0]          irqReq
);

localparam NCH = 2;

reg  [7:0]          ctrlA_q;
reg  [15:0]         count_q;
reg                 countDown_q;
reg                 blockMatch_q;
reg  [7:0]          tempHigh_q;
reg  [15:0]         capture_q;
reg  [`NFLAGS-1:0]  flags_q;
reg  [`NFLAGS-1:0]  mask_q;
reg  [`ADDR_W-1:0]  wAddr_q;
reg  [31:0]         wData_q;
reg  [3:0]          wStrb_q;

wire [3:0]          wgm = ctrlA_q[`WGM_MSB:`WGM_LSB];
wire [16*NCH-1:0]   cmpFlat;
wire [16*NCH-1:0]   visFlat;
wire [NCH-1:0]      ocFlat;
wire [NCH-1:0]      matchSet;

reg                 isPwm;
reg                 isDual;
reg                 updAtBottom;
reg  [15:0]         topValue;
reg  [31:0]         rdMux;
reg                 rdMapped;
reg                 wrMapped;
integer             i;

function nonPwmAct;
    input [1:0] com;
    input       cur;
    begin
        case (com)
            `COM_TOGGLE: nonPwmAct = ~cur;
            `COM_CLEAR:  nonPwmAct = 1'b0;
            `COM_SET:    nonPwmAct = 1'b1;
            default:     nonPwmAct = cur;
        endcase
    end
endfunction

// mode decode: top source, pwm class and buffer update point
always @*
begin
    isPwm = 1'b1;
    isDual = 1'b0;
    updAtBottom = 1'b0;
    topValue = `CNT_MAX;
    case (wgm)
        `WGM_NORMAL:  isPwm = 1'b0;
        `WGM_CTC_A:
        begin
            isPwm = 1'b0;
            topValue = cmpFlat[15:0];
        end
        `WGM_CTC_CAP:
        begin
            isPwm = 1'b0;
            topValue = capture_q;
        end
        `WGM_PC8:
        begin
            isDual = 1'b1;
            topValue = `TOP_8;
        end
        `WGM_PC9:
        begin
            isDual = 1'b1;
            topValue = `TOP_9;
        end
        `WGM_PC10:
        begin
            isDual = 1'b1;
            topValue = `TOP_10;
        end
        `WGM_FP8:     topValue = `TOP_8;
        `WGM_FP9:     topValue = `TOP_9;
        `WGM_FP10:    topValue = `TOP_10;
        `WGM_PFC_CAP:
        begin
            isDual = 1'b1;
            updAtBottom = 1'b1;
            topValue = capture_q;
        end
        `WGM_PFC_A:
        begin
            isDual = 1'b1;
            updAtBottom = 1'b1;
            topValue = cmpFlat[15:0];
        end
        `WGM_PC_CAP:
        begin
            isDual = 1'b1;
            topValue = capture_q;
        end
        `WGM_PC_A:
        begin
            isDual = 1'b1;
            topValue = cmpFlat[15:0];
        end
        `WGM_FP_CAP:  topValue = capture_q;
        `WGM_FP_A:    topValue = cmpFlat[15:0];
        default:      isPwm = 1'b0; // reserved code runs like normal
    endcase
end

// a blocked top match lets the counter run on to max and wrap
wire topHit    = (count_q == topValue) && !blockMatch_q;
wire atBottom  = (count_q == `CNT_BOTTOM);
wire atMax     = (count_q == `CNT_MAX);
wire ovfSingle = isPwm ? (topHit || atMax) : atMax;
wire ovfSet    = timerTick && (isDual ? (countDown_q && atBottom) : ovfSingle);
wire updUp     = updAtBottom ? (countDown_q && atBottom) : (!countDown_q && topHit);
wire updEvent  = timerTick && isPwm && (isDual ? updUp : topHit);

// bus write strobes
wire doWrite   = !awready && !wready && !bvalid;
wire wrByte    = doWrite && wStrb_q[0];
wire wrCount   = wrByte && (wAddr_q == `REG_COUNT);
wire wrForce   = wrByte && (wAddr_q == `REG_FORCE);
wire wrFlags   = wrByte && (wAddr_q == `REG_FLAGS);
wire wrHigh    = wrByte && ((wAddr_q == `REG_CMPA_HI) || (wAddr_q == `REG_CMPB_HI));
wire [NCH-1:0] loWr = {wrByte && (wAddr_q == `REG_CMPB_LO),
                       wrByte && (wAddr_q == `REG_CMPA_LO)};

// counter, direction and match blocking
always @(posedge clock or negedge nrst)
begin
    if (!nrst)
    begin
        count_q      <= `RST_WORD;
        countDown_q  <= 1'b0;
        blockMatch_q <= 1'b0;
    end
    else
    begin
        if (wrCount)
            blockMatch_q <= 1'b1;
        else if (timerTick)
            blockMatch_q <= 1'b0;
        if (wrCount)
            count_q <= wData_q[15:0]; // cpu write beats counting
        else if (timerTick)
        begin
            if (isDual && !countDown_q)
            begin
                if (topHit)
                begin
                    countDown_q <= 1'b1;
                    count_q <= count_q - 16'h0001;
                end
                else
                    count_q <= count_q + 16'h0001;
            end
            else if (isDual)
            begin
                if (atBottom)
                begin
                    countDown_q <= 1'b0;
                    count_q <= count_q + 16'h0001;
                end
                else
                    count_q <= count_q - 16'h0001;
            end
            else if (topHit && isPwm)
                count_q <= `CNT_BOTTOM;
            else if (topHit && wgm != `WGM_NORMAL)
                count_q <= `CNT_BOTTOM;
            else
                count_q <= count_q + 16'h0001;
        end
    end
end

genvar g;
generate
    for (g = 0; g < NCH; g = g + 1)
    begin : chan
        reg  [15:0] cmp_q;
        reg  [15:0] buf_q;
        reg         pend_q;
        reg         pendDown_q;
        reg         oc_q;
        // output mode read live, never buffered with the compare value
        wire [1:0]  com = ctrlA_q[g*`COM_W +: `COM_W];
        wire        forceHit = wrForce && wData_q[g];

        always @(posedge clock or negedge nrst)
        begin
            if (!nrst)
            begin
                cmp_q      <= `RST_WORD;
                buf_q      <= `RST_WORD;
                pend_q     <= 1'b0;
                pendDown_q <= 1'b0;
                oc_q       <= 1'b0;
            end
            else
            begin
                if (loWr[g] && isPwm)
                    buf_q <= {tempHigh_q, wData_q[7:0]};
                if (loWr[g] && !isPwm)
                    cmp_q <= {tempHigh_q, wData_q[7:0]};
                else if (updEvent)
                    cmp_q <= buf_q;
                if (timerTick)
                begin
                    // equality seen now acts one tick later
                    pend_q     <= (count_q == cmp_q) && !blockMatch_q;
                    pendDown_q <= countDown_q;
                end
                if (forceHit && !isPwm)
                    oc_q <= nonPwmAct(com, oc_q);
                else if (timerTick && pend_q && com != `COM_OFF)
                begin
                    if (!isPwm)
                        oc_q <= nonPwmAct(com, oc_q);
                    else if (isDual && com[1])
                        oc_q <= pendDown_q ^ com[0];
                    else if (com[1])
                        oc_q <= com[0];
                end
                else if (timerTick && topHit && isPwm && !isDual && com[1])
                    oc_q <= ~com[0];
            end
        end

        assign cmpFlat[g*16 +: 16] = cmp_q;
        assign visFlat[g*16 +: 16] = isPwm ? buf_q : cmp_q;
        assign ocFlat[g]           = oc_q;
        assign matchSet[g]         = timerTick && pend_q;
    end
endgenerate

wire [`NFLAGS-1:0] flagSet = {matchSet, ovfSet};
wire [`NFLAGS-1:0] flagClr = irqAck | (wrFlags ? wData_q[`NFLAGS-1:0] : `RST_FLAGS);

always @*
begin
    wrMapped = 1'b1;
    case (wAddr_q)
        `REG_CTRL_A, `REG_FORCE, `REG_COUNT, `REG_CMPA_LO, `REG_CMPA_HI,
        `REG_CMPB_LO, `REG_CMPB_HI, `REG_CAPTURE, `REG_FLAGS, `REG_MASK:
            wrMapped = 1'b1;
        default:
            wrMapped = 1'b0;
    endcase
end

always @*
begin
    rdMux = `DATA_ZERO;
    rdMapped = 1'b1;
    case (araddr)
        `REG_CTRL_A:  rdMux[7:0] = ctrlA_q;
        `REG_FORCE:   rdMux = `DATA_ZERO;
        `REG_COUNT:   rdMux[15:0] = count_q;
        `REG_CMPA_LO: rdMux[7:0] = visFlat[7:0];
        `REG_CMPA_HI: rdMux[7:0] = visFlat[15:8];
        `REG_CMPB_LO: rdMux[7:0] = visFlat[23:16];
        `REG_CMPB_HI: rdMux[7:0] = visFlat[31:24];
        `REG_CAPTURE: rdMux[15:0] = capture_q;
        `REG_FLAGS:   rdMux[`NFLAGS-1:0] = flags_q;
        `REG_MASK:    rdMux[`NFLAGS-1:0] = mask_q;
        default:      rdMapped = 1'b0;
    endcase
end

// registers, flags, pins and the bus slave
always @(posedge clock or negedge nrst)
begin
    if (!nrst)
    begin
        ctrlA_q    <= `RST_BYTE;
        tempHigh_q <= `RST_BYTE;
        capture_q  <= `RST_WORD;
        flags_q    <= `RST_FLAGS;
        mask_q     <= `RST_FLAGS;
        irqReq     <= `RST_FLAGS;
        pinOut     <= 2'h0;
        pinOe      <= 2'h0;
        wAddr_q    <= `REG_CTRL_A;
        wData_q    <= `DATA_ZERO;
        wStrb_q    <= 4'h0;
        awready    <= 1'b1;
        wready     <= 1'b1;
        bvalid     <= 1'b0;
        bresp      <= `RESP_OKAY;
        arready    <= 1'b1;
        rvalid     <= 1'b0;
        rresp      <= `RESP_OKAY;
        rdata      <= `DATA_ZERO;
    end
    else
    begin
        // a mode change leaves the output bits untouched
        if (wrByte && wAddr_q == `REG_CTRL_A)
            ctrlA_q <= wData_q[7:0];
        if (wrHigh)
            tempHigh_q <= wData_q[7:0];
        if (wrByte && wAddr_q == `REG_CAPTURE)
            capture_q <= wData_q[15:0];
        if (wrByte && wAddr_q == `REG_MASK)
            mask_q <= wData_q[`NFLAGS-1:0];
        flags_q <= (flags_q & ~flagClr) | flagSet;
        irqReq  <= flags_q & mask_q;
        for (i = 0; i < NCH; i = i + 1)
        begin
            pinOut[i] <= (ctrlA_q[i*`COM_W +: `COM_W] != `COM_OFF) ? ocFlat[i] : portOut[i];
            pinOe[i]  <= portDir[i];
        end
        if (awvalid && awready)
        begin
            wAddr_q <= awaddr;
            awready <= 1'b0;
        end
        if (wvalid && wready)
        begin
            wData_q <= wdata;
            wStrb_q <= wstrb;
            wready  <= 1'b0;
        end
        if (doWrite)
        begin
            bvalid <= 1'b1;
            bresp  <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (bvalid && bready)
        begin
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
        end
        if (arvalid && arready)
        begin
            rdata   <= rdMux;
            rresp   <= rdMapped ? `RESP_OKAY : `RESP_SLVERR;
            rvalid  <= 1'b1;
            arready <= 1'b0;
        end
        if (rvalid && rready)
        begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end
end

endmodule
`default_nettype wire

// ### compare_unit_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "compare_unit_map.vh"

module compare_unit_checker (
    input wire logic       clock,
    input wire logic       nrst,
    input wire logic       timerTick,
    input wire logic [1:0] portDir,
    input wire logic [2:0] irqAck,
    input wire logic       awvalid,
    input wire logic       awready,
    input wire logic       wvalid,
    input wire logic       wready,
    input wire logic       bvalid,
    input wire logic       bready,
    input wire logic       arvalid,
    input wire logic       arready,
    input wire logic       rvalid,
    input wire logic       rready,
    input wire logic [1:0] pinOe,
    input wire logic [2:0] irqReq
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    a_oe_from_dir: assert property ($past(nrst) |-> pinOe == $past(portDir))
        else $error("pin enable not taken from port direction");
    a_w_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
        else $error("write response late");
    a_w_refuse: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while response pending");
    a_b_release: assert property (bvalid && bready |=> !bvalid)
        else $error("write response not released");
    a_ar_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read data late");
    a_ar_refuse: assert property (rvalid |-> !arready)
        else $error("read taken while data pending");
    a_r_release: assert property (rvalid && rready |=> !rvalid && arready)
        else $error("read data not released");
    // the quiet first cycle keeps a fresh match from legally setting the flag again
    a_ack_clears: assert property (irqAck[1] && !timerTick ##1 !timerTick |=> !irqReq[1])
        else $error("serviced request still raised");
endmodule

bind output_compare_waveform_unit compare_unit_checker u_chk (
    .clock(clock), .nrst(nrst), .timerTick(timerTick), .portDir(portDir), .irqAck(irqAck),
    .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
    .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
    .rvalid(rvalid), .rready(rready), .pinOe(pinOe), .irqReq(irqReq)
);
`default_nettype wire

// ### test_output_compare_waveform_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "compare_unit_map.vh"
`define CHECK_EQ(got, exp, msg) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) \
        begin \
            num_errors++; \
            $display("mismatch at %0t: %s", $time, msg); \
        end \
    end

module test_output_compare_waveform_unit;
    logic                clock = 1'b0;
    logic                nrst = 1'b0;
    logic                timerTick = 1'b0;
    logic [1:0]          portOut = 2'b01;
    logic [1:0]          portDir = 2'b00;
    logic [2:0]          irqAck = 3'b000;
    logic [`ADDR_W-1:0]  awaddr = 8'h00;
    logic [`ADDR_W-1:0]  araddr = 8'h00;
    logic                awvalid = 1'b0;
    logic                wvalid = 1'b0;
    logic                bready = 1'b0;
    logic                arvalid = 1'b0;
    logic                rready = 1'b0;
    logic [31:0]         wdata = `DATA_ZERO;
    logic [3:0]          wstrb = 4'hF;
    wire logic           awready, wready, bvalid, arready, rvalid;
    wire logic [1:0]     bresp, rresp, pinOut, pinOe;
    wire logic [31:0]    rdata;
    wire logic [2:0]     irqReq;
    logic [33:0]         expQ[$];
    logic [33:0]         note;
    int                  num_errors = 0;
    int                  total_checks = 0;
    logic [15:0]         c;
    logic                o;
    logic [1:0]          modes [4] = '{`COM_TOGGLE, `COM_TOGGLE, `COM_CLEAR, `COM_SET};

    output_compare_waveform_unit dut (
        .clock(clock), .nrst(nrst), .timerTick(timerTick), .portOut(portOut),
        .portDir(portDir), .irqAck(irqAck), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .pinOut(pinOut), .pinOe(pinOe), .irqReq(irqReq)
    );

    always #5 clock = ~clock;

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge clock);
            timerTick <= 1'b1;
            @(posedge clock);
            timerTick <= 1'b0;
        end
    endtask

    task automatic bus_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int i;
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 100; i++)
        begin
            @(posedge clock);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid)
                break;
        end
        bready <= 1'b0;
        if (i == 100)
        begin
            num_errors++;
            wrap_up();
        end
        `CHECK_EQ(bresp, r, "write response")
    endtask

    // the monitor below compares the note when the data arrives
    task automatic bus_read(input logic [7:0] a, input logic [1:0] r, input logic [31:0] d);
        int i;
        expQ.push_back({r, d});
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 100 && !rvalid; i++)
        begin
            @(posedge clock);
            if (arvalid && arready)
                arvalid <= 1'b0;
        end
        rready <= 1'b0;
        if (i == 100)
        begin
            num_errors++;
            wrap_up();
        end
    endtask

    task automatic write_cmp(input logic [7:0] hi, input logic [15:0] v);
        bus_write(hi, {24'h00_0000, v[15:8]}, `RESP_OKAY);
        bus_write(hi - 8'h04, {24'h00_0000, v[7:0]}, `RESP_OKAY);
    endtask

    always @(posedge clock)
        if (rvalid && rready)
        begin
            note = expQ.size() > 0 ? expQ.pop_front() : 34'bx;
            `CHECK_EQ({rresp, rdata}, note, "read result")
        end

    initial
    begin
        void'($urandom(90));
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        bus_read(`REG_COUNT, `RESP_OKAY, `DATA_ZERO);
        bus_read(8'h28, `RESP_SLVERR, `DATA_ZERO);
        bus_write(8'h28, 32'h0000_00FF, `RESP_SLVERR);
        $display("test reset_and_map done");
        c = 16'h0040 + 16'($urandom % 64);
        portDir <= 2'($urandom);
        write_cmp(`REG_CMPA_HI, c);
        write_cmp(`REG_CMPB_HI, c);
        bus_read(`REG_CMPA_HI, `RESP_OKAY, {24'h00_0000, c[15:8]});
        bus_read(`REG_CMPB_LO, `RESP_OKAY, {24'h00_0000, c[7:0]});
        bus_write(`REG_COUNT, {16'h0000, c - 16'h0002}, `RESP_OKAY);
        bus_write(`REG_MASK, 32'h0000_0002, `RESP_OKAY);
        tick(2);
        bus_read(`REG_FLAGS, `RESP_OKAY, `DATA_ZERO);
        tick(2);
        bus_read(`REG_FLAGS, `RESP_OKAY, 32'h0000_0006);
        `CHECK_EQ(irqReq, 3'b010, "match request")
        @(posedge clock);
        irqAck <= 3'b010;
        @(posedge clock);
        irqAck <= 3'b000;
        bus_write(`REG_FLAGS, 32'h0000_0004, `RESP_OKAY);
        bus_read(`REG_FLAGS, `RESP_OKAY, `DATA_ZERO);
        `CHECK_EQ(irqReq, 3'b000, "request after service")
        $display("test match_flags done");
        // the match at the written value is swallowed, counting goes on
        bus_write(`REG_COUNT, {16'h0000, c}, `RESP_OKAY);
        tick(3);
        bus_read(`REG_FLAGS, `RESP_OKAY, `DATA_ZERO);
        bus_read(`REG_COUNT, `RESP_OKAY, {16'h0000, c + 16'h0003});
        bus_write(`REG_COUNT, 32'h0000_FFFF, `RESP_OKAY);
        tick(1);
        bus_read(`REG_COUNT, `RESP_OKAY, `DATA_ZERO);
        bus_read(`REG_FLAGS, `RESP_OKAY, 32'h0000_0001);
        bus_write(`REG_FLAGS, 32'h0000_0007, `RESP_OKAY);
        $display("test block_and_wrap done");
        bus_write(`REG_CTRL_A, {24'h00_0000, `WGM_CTC_A, 4'h0}, `RESP_OKAY);
        write_cmp(`REG_CMPA_HI, 16'h0005);
        bus_write(`REG_COUNT, `DATA_ZERO, `RESP_OKAY);
        tick(8);
        bus_read(`REG_COUNT, `RESP_OKAY, 32'h0000_0002);
        bus_read(`REG_FLAGS, `RESP_OKAY, 32'h0000_0002);
        bus_write(`REG_FLAGS, 32'h0000_0007, `RESP_OKAY);
        $display("test clear_on_match done");
        o = 1'b0;
        // mode set without a match shows the untouched bit on the pin
        bus_write(`REG_CTRL_A, {28'h000_0000, 2'b00, `COM_SET}, `RESP_OKAY);
        repeat (2) @(posedge clock);
        `CHECK_EQ(pinOut[0], 1'b0, "output bit after reset")
        foreach (modes[i])
        begin
            bus_write(`REG_CTRL_A, {28'h000_0000, 2'b00, modes[i]}, `RESP_OKAY);
            bus_write(`REG_FORCE, 32'h0000_0001, `RESP_OKAY);
            repeat (2) @(posedge clock);
            o = modes[i] == `COM_TOGGLE ? !o : modes[i][0];
            `CHECK_EQ(pinOut, {portOut[1], o}, "forced output")
        end
        bus_write(`REG_CTRL_A, {24'h00_0000, `WGM_CTC_A, 2'b00, `COM_SET}, `RESP_OKAY);
        repeat (2) @(posedge clock);
        `CHECK_EQ(pinOut[0], o, "bit kept over mode change")
        bus_write(`REG_FORCE, 32'h0000_0001, `RESP_OKAY);
        bus_read(`REG_FLAGS, `RESP_OKAY, `DATA_ZERO);
        bus_read(`REG_COUNT, `RESP_OKAY, 32'h0000_0002);
        portOut <= 2'b00;
        bus_write(`REG_CTRL_A, `DATA_ZERO, `RESP_OKAY);
        bus_write(`REG_FORCE, 32'h0000_0001, `RESP_OKAY);
        `CHECK_EQ(pinOut[0], 1'b0, "port value when mode is off")
        bus_write(`REG_CTRL_A, {28'h000_0000, 2'b00, `COM_TOGGLE}, `RESP_OKAY);
        repeat (2) @(posedge clock);
        `CHECK_EQ(pinOut[0], 1'b1, "force with mode off")
        $display("test output_bit done");
        bus_write(`REG_CTRL_A, {24'h00_0000, `WGM_FP8, 4'h0}, `RESP_OKAY);
        bus_write(`REG_COUNT, 32'h0000_0003, `RESP_OKAY);
        write_cmp(`REG_CMPA_HI, 16'h0010);
        tick(4);
        // the old value 5 still matches: the buffer waits for top
        bus_read(`REG_FLAGS, `RESP_OKAY, 32'h0000_0002);
        bus_read(`REG_CMPA_LO, `RESP_OKAY, 32'h0000_0010);
        $display("test buffered_compare done");
        wrap_up();
    end
endmodule
`default_nettype wire
